// ==== shared/strap_pkg.sv ====
// Package for the reset strap configuration loader.
// Assumes one 25 MHz core clock and a plain register port.

package strap_pkg;

  // ==========================================================
  // Strap pin positions in the sampled vector
  localparam int STRAP_W = 13;
  localparam int IDX_EMISSION = 0;
  localparam int IDX_FLOW = 1;
  localparam int IDX_LINKUP = 2;
  localparam int IDX_AN_HI = 3;
  localparam int IDX_AN_LO = 4;
  localparam int IDX_MGMT_HI = 5;
  localparam int IDX_MGMT_LO = 6;
  localparam int IDX_START = 7;
  localparam int IDX_P6_HI = 8;
  localparam int IDX_P6_LO = 9;
  localparam int IDX_P6_ROLE = 10;
  localparam int IDX_P6_SPEED = 11;
  localparam int IDX_INBAND = 12;

  // ==========================================================
  // Register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_STRAP_RAW = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam int CTRL_SOFT_RST = 0;
  localparam int CTRL_START = 1;
  localparam logic [12:0] STRAP_RST = 13'h0000;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SETTLE_NS = 80;
  localparam int SETTLE_CYC =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    S_FLOAT = 2'b00,
    S_CAPTURE = 2'b01,
    S_RUN = 2'b10
  } load_state_t;

  typedef enum logic [1:0] {
    MGMT_MDIO = 2'b00,
    MGMT_I2C = 2'b01,
    MGMT_SPI = 2'b10
  } mgmt_t;

  typedef enum logic [1:0] {
    P6_RGMII = 2'b00,
    P6_RMII = 2'b01,
    P6_RSVD = 2'b10,
    P6_MII = 2'b11
  } p6_mode_t;

  typedef struct packed {
    logic emission_filter_en;
    logic flow_ctrl_en;
    logic fast_linkup;
    logic auto_mdix_en;
    logic autoneg_en;
    logic linkup_rsvd;
    logic nand_tree;
    logic full_duplex_forced;
    logic force_mdix;
    logic force_mdi;
    mgmt_t mgmt_sel;
    logic start_on_reset;
    p6_mode_t p6_mode;
    logic p6_mac_role;
    logic p6_refclk_out_en;
    logic p6_refclk_in_sel;
    logic p6_speed_1000;
    logic inband_en;
  } strap_cfg_t;

  localparam strap_cfg_t CFG_RST = '0;

endpackage : strap_pkg

// ==== src/reset_strap_config_loader.sv ====
// Reset strap configuration loader: floats the strap pins in reset,
// samples them at release and decodes the device-wide settings.
// Assumes board pull resistors and a synchronous register master.
//
// How it works
// - While reset or soft reset is active every strap pin is floated.
// - Pin levels are captured at reset release and become the setup.
// - After capture every strap pin is driven with its normal output.
// - A software reset floats the pins again and recaptures them.
// - A low emission strap enables the transmit filter, high disables.
// - A low flow strap disables flow control, high enables it.
// - A low link-up strap selects fast link-up without auto modes.
// - In normal link-up the two-bit code picks reserved, off, NAND, on.
// - Fast link-up forces full duplex and MDI-X on low, MDI on high.
// - Code 00 picks MDIO, 01 I2C and 1x SPI management.
// - A low start strap holds forwarding until the start bit is set.
// - Port 6 code 00 RGMII, 01 RMII, 10 reserved, 11 MII.
// - In MII a high role strap makes port 6 the MAC side.
// - In RMII a low role strap drives the 50 MHz reference out.
// - A low speed strap gives 1000 Mbps, high gives 10/100 Mbps.
// - A high in-band strap enables management over switch frames.
//
// Local design decisions: strobed register access and the register addresses.

`timescale 1ns/100ps

module reset_strap_config_loader (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Strap pins
  input wire logic [strap_pkg::STRAP_W-1:0] i_strap_pin,
  output logic [strap_pkg::STRAP_W-1:0] o_strap_out,
  output logic [strap_pkg::STRAP_W-1:0] o_strap_oe_n,
  // Normal pin function
  input wire logic [strap_pkg::STRAP_W-1:0] i_func_out,
  // Register port
  input wire logic [strap_pkg::ADDR_W-1:0] i_addr,
  input wire logic [strap_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [strap_pkg::DATA_W-1:0] o_rd_data,
  // Configuration out
  output strap_pkg::strap_cfg_t o_cfg,
  output logic o_cfg_valid,
  output logic o_forward_en
);
  import strap_pkg::*;

  // ==========================================================
  // Pin synchroniser
  logic [STRAP_W-1:0] pin_meta;
  logic [STRAP_W-1:0] pin_sync;

  // No reset, so the stages keep sampling while reset is held
  always_ff @(posedge i_core_clk) begin
    pin_meta <= i_strap_pin;
    pin_sync <= pin_meta;
  end

  // ==========================================================
  // Load sequencer
  load_state_t state;
  load_state_t next_state;
  logic [2:0] settle_cnt;
  logic [2:0] next_settle_cnt;
  logic [STRAP_W-1:0] strap;
  logic start_bit;

  wire sel_raw = (i_addr == OFS_STRAP_RAW);
  wire sel_ctrl = (i_addr == OFS_CTRL);
  wire sel_status = (i_addr == OFS_STATUS);
  wire wr_ctrl = i_wr && sel_ctrl;
  wire soft_rst = wr_ctrl && i_wr_data[CTRL_SOFT_RST];
  wire settle_done = (settle_cnt == 3'(SETTLE_CYC - 1));

  always_comb begin
    next_state = state;
    next_settle_cnt = settle_cnt;
    case (state)
      S_FLOAT: begin
        next_settle_cnt = settle_cnt + 3'h1;
        if (settle_done) begin
          next_state = S_CAPTURE;
        end
      end
      S_CAPTURE: begin
        next_state = S_RUN;
      end
      S_RUN: begin
        next_state = S_RUN;
      end
      default: begin
        next_state = S_FLOAT;
      end
    endcase
    // Soft reset restarts the whole load sequence
    if (soft_rst) begin
      next_state = S_FLOAT;
      next_settle_cnt = 3'h0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= S_FLOAT;
      settle_cnt <= 3'h0;
    end else begin
      state <= next_state;
      settle_cnt <= next_settle_cnt;
    end
  end

  // ==========================================================
  // Capture latch
  // Only the capture state loads it; pin activity in run is ignored
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      strap <= STRAP_RST;
    end else if (state == S_CAPTURE) begin
      strap <= pin_sync;
    end
  end

  // ==========================================================
  // Pin drivers
  // Pins float until capture is done, so no driver fights the pulls
  // Soft reset lets go of the pins at once; otherwise the synchroniser
  // would hand the capture a level the device itself was driving
  wire drive = (state == S_RUN) && !soft_rst;
  wire [STRAP_W-1:0] next_oe_n = drive ? '0 : '1;
  wire [STRAP_W-1:0] next_out = drive ? i_func_out : '0;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_strap_oe_n <= '1;
      o_strap_out <= '0;
    end else begin
      o_strap_oe_n <= next_oe_n;
      o_strap_out <= next_out;
    end
  end

  // ==========================================================
  // Decode
  wire normal = strap[IDX_LINKUP];
  wire [1:0] an_code = {strap[IDX_AN_HI], strap[IDX_AN_LO]};
  wire [1:0] mg_code = {strap[IDX_MGMT_HI], strap[IDX_MGMT_LO]};
  wire [1:0] p6_code = {strap[IDX_P6_HI], strap[IDX_P6_LO]};
  wire role = strap[IDX_P6_ROLE];
  wire is_mii = (p6_code == P6_MII);
  wire is_rmii = (p6_code == P6_RMII);
  wire mgmt_t dec_mgmt = mg_code[1] ? MGMT_SPI : mgmt_t'(mg_code);
  strap_cfg_t next_cfg;

  always_comb begin
    next_cfg = CFG_RST;
    next_cfg.emission_filter_en = !strap[IDX_EMISSION];
    next_cfg.flow_ctrl_en = strap[IDX_FLOW];
    next_cfg.fast_linkup = !normal;
    next_cfg.auto_mdix_en = normal;
    next_cfg.autoneg_en = normal && (an_code == 2'h3);
    next_cfg.linkup_rsvd = normal && (an_code == 2'h0);
    next_cfg.nand_tree = normal && (an_code == 2'h2);
    next_cfg.full_duplex_forced = !normal;
    next_cfg.force_mdix = !normal && !strap[IDX_AN_HI];
    next_cfg.force_mdi = !normal && strap[IDX_AN_HI];
    next_cfg.mgmt_sel = dec_mgmt;
    next_cfg.start_on_reset = strap[IDX_START];
    next_cfg.p6_mode = p6_mode_t'(p6_code);
    next_cfg.p6_mac_role = is_mii && role;
    next_cfg.p6_refclk_out_en = is_rmii && !role;
    next_cfg.p6_refclk_in_sel = is_rmii && role;
    next_cfg.p6_speed_1000 = !strap[IDX_P6_SPEED];
    next_cfg.inband_en = strap[IDX_INBAND];
  end

  // ==========================================================
  // Control register and outputs
  // Forwarding stays off until the load has finished
  wire next_fwd = drive && (strap[IDX_START] || start_bit);

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      start_bit <= 1'b0;
    end else if (soft_rst) begin
      start_bit <= 1'b0;
    end else if (wr_ctrl) begin
      start_bit <= i_wr_data[CTRL_START];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cfg <= CFG_RST;
      o_cfg_valid <= 1'b0;
      o_forward_en <= 1'b0;
    end else begin
      o_cfg <= next_cfg;
      o_cfg_valid <= drive;
      o_forward_en <= next_fwd;
    end
  end

  // ==========================================================
  // Register reads
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    if (sel_raw) begin
      rd_mux[STRAP_W-1:0] = strap;
    end else if (sel_ctrl) begin
      rd_mux[CTRL_START] = start_bit;
    end else if (sel_status) begin
      rd_mux[1:0] = state;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= i_rd ? rd_mux : '0;
    end
  end

  // ==========================================================
  // Assertions
  a_float_while_load: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (state != S_RUN || soft_rst) |=> (o_strap_oe_n == '1))
    else $error("strap pin driven during load");

  a_capture_pins: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (state == S_CAPTURE) |=> (strap == $past(pin_sync)))
    else $error("strap capture wrong");

  a_drive_after_load: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (state == S_RUN && !soft_rst) |=>
      (o_strap_oe_n == '0) && (o_strap_out == $past(i_func_out)))
    else $error("strap pin not driven in run");

  a_soft_reload: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (soft_rst && state == S_RUN) |=>
      (state == S_FLOAT) ##[1:4] (state == S_CAPTURE))
    else $error("soft reset did not reload");

  a_filter_flow: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    o_cfg_valid |->
      (o_cfg.emission_filter_en == !strap[IDX_EMISSION]) &&
      (o_cfg.flow_ctrl_en == strap[IDX_FLOW]))
    else $error("filter or flow decode wrong");

  a_linkup_decode: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (o_cfg_valid && normal) |->
      (o_cfg.autoneg_en == (an_code == 2'h3)) && !o_cfg.force_mdi &&
      (o_cfg.nand_tree == (an_code == 2'h2)))
    else $error("normal link-up decode wrong");

  a_fast_linkup: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (o_cfg_valid && !normal) |->
      o_cfg.full_duplex_forced && !o_cfg.autoneg_en &&
      (o_cfg.force_mdix == !strap[IDX_AN_HI]))
    else $error("fast link-up decode wrong");

  a_mgmt_sel: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (o_cfg_valid && mg_code[1]) |-> (o_cfg.mgmt_sel == MGMT_SPI))
    else $error("management select wrong");

  a_start_gate: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (drive && !strap[IDX_START] && !start_bit) |=> !o_forward_en)
    else $error("forwarding before start bit");

  a_p6_clock: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    o_cfg_valid |->
      !(o_cfg.p6_refclk_out_en && o_cfg.p6_refclk_in_sel))
    else $error("port 6 reference both ways");

  a_hold_in_run: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (state == S_RUN) ##1 (state == S_RUN) |-> $stable(strap))
    else $error("captured straps changed in run");

  c_first_run: cover property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (state == S_CAPTURE) ##1 (state == S_RUN));

  c_soft_reset: cover property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    soft_rst && (state == S_RUN));

  c_start_by_sw: cover property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    !o_forward_en && !strap[IDX_START] ##1 o_forward_en);

endmodule : reset_strap_config_loader

// ==== bench/strap_board_model.sv ====
// Board strap resistors: one weak pull on every strap line.
// Assumes the device floats a line by raising its active-low enable.
`timescale 1ns/100ps

module strap_board_model (
  // Pull levels
  input wire logic [strap_pkg::STRAP_W-1:0] i_pull,
  // Device side
  input wire logic [strap_pkg::STRAP_W-1:0] i_out,
  input wire logic [strap_pkg::STRAP_W-1:0] i_oe_n,
  // Resolved wire
  output logic [strap_pkg::STRAP_W-1:0] o_pin
);
  import strap_pkg::*;
  // ==========================================================
  // Wire resolution
  // A floated line settles to its pull, not to the last driven level
  assign o_pin = (i_oe_n & i_pull) | (~i_oe_n & i_out);
endmodule : strap_board_model

// ==== bench/reset_strap_config_loader_test.sv ====
// Testbench for the reset strap configuration loader.
// Assumes the board model resolves every floated strap pin from its pull.
`timescale 1ns/100ps

module reset_strap_config_loader_test;
  import strap_pkg::*;
  // ==========================================================
  // Signals
  localparam logic [STRAP_W-1:0] DEF = 13'h00FF;
  logic i_core_clk;
  logic i_rstn;
  logic [STRAP_W-1:0] pull, pin, s_out, s_oe_n, func_out;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wr_data, o_rd_data;
  logic i_wr, i_rd, o_cfg_valid, o_forward_en;
  strap_cfg_t o_cfg;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [STRAP_W-1:0] pats [6] = '{13'h1F00, 13'h0A4C, 13'h0514,
    13'h0624, 13'h0008, 13'h0364};

  strap_board_model board_u (.i_pull(pull), .i_out(s_out),
    .i_oe_n(s_oe_n), .o_pin(pin));

  reset_strap_config_loader dut_u (.i_core_clk(i_core_clk),
    .i_rstn(i_rstn), .i_strap_pin(pin), .o_strap_out(s_out),
    .o_strap_oe_n(s_oe_n), .i_func_out(func_out), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
    .o_rd_data(o_rd_data), .o_cfg(o_cfg), .o_cfg_valid(o_cfg_valid),
    .o_forward_en(o_forward_en));

  initial begin
    i_core_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) i_core_clk = ~i_core_clk;
  end

  // ==========================================================
  // Checks and closing
  task automatic end_of_test;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_v

  task automatic cmp_cfg(input strap_cfg_t got, input strap_cfg_t exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_cfg

  function automatic strap_cfg_t exp_cfg(input logic [STRAP_W-1:0] p);
    strap_cfg_t c;
    logic nrm;
    logic [1:0] an, pm;
    c = CFG_RST;
    nrm = p[IDX_LINKUP];
    an = {p[IDX_AN_HI], p[IDX_AN_LO]};
    pm = {p[IDX_P6_HI], p[IDX_P6_LO]};
    c.emission_filter_en = ~p[IDX_EMISSION];
    c.flow_ctrl_en = p[IDX_FLOW];
    c.fast_linkup = ~nrm;
    c.auto_mdix_en = nrm;
    c.autoneg_en = nrm && an == 2'h3;
    c.linkup_rsvd = nrm && an == 2'h0;
    c.nand_tree = nrm && an == 2'h2;
    c.full_duplex_forced = ~nrm;
    c.force_mdix = ~nrm && ~p[IDX_AN_HI];
    c.force_mdi = ~nrm && p[IDX_AN_HI];
    c.mgmt_sel = p[IDX_MGMT_LO] ? MGMT_I2C : MGMT_MDIO;
    if (p[IDX_MGMT_HI]) begin
      c.mgmt_sel = MGMT_SPI;
    end
    c.start_on_reset = p[IDX_START];
    c.p6_mode = p6_mode_t'(pm);
    c.p6_mac_role = pm == 2'h3 && p[IDX_P6_ROLE];
    c.p6_refclk_out_en = pm == 2'h1 && !p[IDX_P6_ROLE];
    c.p6_refclk_in_sel = pm == 2'h1 && p[IDX_P6_ROLE];
    c.p6_speed_1000 = ~p[IDX_P6_SPEED];
    c.inband_en = p[IDX_INBAND];
    return c;
  endfunction : exp_cfg

  // ==========================================================
  // Bus and reset helpers
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    d = o_rd_data;
  endtask : reg_rd

  // Bounded wait; a hang ends the run at once
  task automatic wait_run;
    int n;
    n = 0;
    while (o_cfg_valid !== 1'b1 && n < 20) begin
      @(negedge i_core_clk);
      n++;
    end
    if (o_cfg_valid !== 1'b1) begin
      cmp_v(32'(o_cfg_valid), 32'h1);
      end_of_test();
    end
  endtask : wait_run

  task automatic hard_reset(input logic [STRAP_W-1:0] p);
    @(posedge i_core_clk);
    pull <= p;
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    cmp_v(32'(s_oe_n), 32'h1FFF);
    cmp_v(32'(s_out), 32'h0);
    i_rstn <= 1'b1;
    wait_run();
  endtask : hard_reset

  // ==========================================================
  // Scenarios
  task automatic check_pattern(input logic [STRAP_W-1:0] p);
    logic [31:0] d;
    hard_reset(p);
    cmp_cfg(o_cfg, exp_cfg(p));
    cmp_v(32'(s_oe_n), 32'h0);
    reg_rd(OFS_STRAP_RAW, d);
    cmp_v(d, 32'(p));
    cmp_v(32'(o_forward_en), 32'(p[IDX_START]));
  endtask : check_pattern

  task automatic soft_reload;
    logic [31:0] d;
    @(posedge i_core_clk);
    pull <= 13'h1F00;
    func_out <= 13'h1555;
    repeat (4) @(posedge i_core_clk);
    @(negedge i_core_clk);
    cmp_cfg(o_cfg, exp_cfg(DEF));
    cmp_v(32'(s_out), 32'h1555);
    reg_wr(OFS_CTRL, 32'h1);
    repeat (2) @(posedge i_core_clk);
    @(negedge i_core_clk);
    cmp_v(32'(s_oe_n), 32'h1FFF);
    cmp_v(32'(o_cfg_valid), 32'h0);
    wait_run();
    cmp_cfg(o_cfg, exp_cfg(13'h1F00));
    cmp_v(32'(o_forward_en), 32'h0);
    reg_wr(OFS_CTRL, 32'h2);
    repeat (3) @(posedge i_core_clk);
    @(negedge i_core_clk);
    cmp_v(32'(o_forward_en), 32'h1);
    reg_rd(OFS_CTRL, d);
    cmp_v(d, 32'h2);
    reg_rd(OFS_STATUS, d);
    cmp_v(d, 32'h2);
    reg_rd(8'h0C, d);
    cmp_v(d, 32'h0);
  endtask : soft_reload

  initial begin
    i_rstn = 1'b0;
    pull = DEF;
    func_out = '0;
    i_addr = '0;
    i_wr_data = '0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (20) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    wait_run();
    cmp_cfg(o_cfg, exp_cfg(DEF));
    foreach (pats[k]) begin
      check_pattern(pats[k]);
    end
    hard_reset(DEF);
    soft_reload();
    end_of_test();
  end
endmodule : reset_strap_config_loader_test
